// *** verilog/i2c_evt_regs.svh ***
// Register offsets, field positions and reset values of the event block.
`ifndef I2C_EVT_REGS_SVH
`define I2C_EVT_REGS_SVH

// Byte addresses on the register bus.
`define OFF_EVENT_CLR 32'h0001D300
`define OFF_IRQ_STATUS 32'h0001D304
`define OFF_NEW_EVENT 32'h0001D308
`define OFF_ENABLE 32'h0001D30C
`define OFF_IRQ_MASK 32'h0001D350
`define OFF_SOFT_RESET 32'h0001D354

// Reset values and implemented-bit masks.
`define ENB_RESET 32'h74DE5F3F
`define ENB_IMPL 32'h77DE5F3F
`define NEW_IMPL 32'h01DE5F3F
`define IRQ_MASK_RESET 32'h00000000
`define ZERO_WORD 32'h00000000

// New-event field groups, bit 0 of the field map is the word's MSB.
`define GRP_DIAG_MBOX 32'h01C00000
`define GRP_SLAVE_ERR 32'h001E0000
`define GRP_MASTER_BOOT 32'h00005F00
`define GRP_MASTER_ERR 32'h0000003F

// Single field positions as physical bit indices.
`define EVB_SD 28
`define EVB_DIAG_HISTORY_FILLING 25
`define EVB_DIAG_COMMAND_DONE 24
`define EVB_INBOX_WRITE 23
`define EVB_OUTBOX_READ 22
`define EVB_MTD 14
`define EVB_BOOT_LOAD_ERROR 11
`define SRST_BIT 0

// Bus encodings.
`define HTRANS_NONSEQ 2'h2

`endif

// *** verilog/i2c_evt_pkg.sv ***
// Types shared by the event block and its bench.
package i2c_evt_pkg;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ahb_req_t;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } ahb_rsp_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_EVENT_CLR,
    SEL_IRQ_STATUS,
    SEL_NEW_EVENT,
    SEL_ENABLE,
    SEL_IRQ_MASK,
    SEL_SOFT_RESET
  } reg_sel_t;

endpackage : i2c_evt_pkg

// *** verilog/sticky_w1c.sv ***
// Sticky status word: hardware sets bits, software clears by writing ones.
`timescale 1ns/1ps

module sticky_w1c #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Hardware set, one cycle per bit
  input wire logic [WIDTH-1:0] set,
  // Software clear
  input wire logic clear_wr,
  input wire logic [WIDTH-1:0] clear_data,
  // Stored status
  output logic [WIDTH-1:0] status
);

  logic [WIDTH-1:0] next_status;

  // A set in the same cycle as its clear survives, so no event is lost.
  always_comb begin
    next_status = status;
    if (clear_wr) begin
      next_status = next_status & ~clear_data;
    end
    next_status = next_status | set;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

endmodule : sticky_w1c

// *** verilog/i2c_event_enable_gating.sv ***
// Event enable mask, write-one-to-set new events and interrupt status.
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "i2c_evt_regs.svh"

// Contract
// - A latched event reaches interrupt status only while its enable is 1.
// - Enable mask is read/write at 0x1D30C, resetting to 0x74DE_5F3F.
// - History filling enable, field bit 06, resets to 0.
// - Command done enable bit 07 resets 0; transaction done bit 03 resets 1.
// - New-event bits 07 to 09 reset to 0 and set on written ones.
// - New-event bits 11 to 14, slave errors, reset 0 and set on ones.
// - New-event bits 17 and 19 to 23 reset 0 and set on ones.
// - New-event bits 26 to 31, master errors, reset 0 and set on ones.
// - Enables for master done (17) and boot error (20) reset to 1.
// - Enables for mailbox write (08) and read (09) reset to 1.
// - Event register write or status read clears all new-event bits.
// - While soft reset is held, new-event bits stay cleared.
module i2c_event_enable_gating (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register bus
  input wire i2c_evt_pkg::ahb_req_t bus_req,
  output i2c_evt_pkg::ahb_rsp_t bus_rsp,
  // Event sources
  input wire logic [31:0] event_in,
  input wire logic [31:0] latched_event,
  // Event state towards the controller
  output logic [31:0] new_event,
  output logic [31:0] event_enable,
  output logic soft_block_reset,
  output logic irq
);

  logic addr_ok;
  logic addr_rd;
  i2c_evt_pkg::reg_sel_t addr_sel;
  i2c_evt_pkg::reg_sel_t data_sel;
  logic data_wr;
  logic wr_new;
  logic wr_enable;
  logic wr_event_clr;
  logic wr_status;
  logic wr_irq_mask;
  logic wr_soft_reset;
  logic status_rd;
  logic clear_new;
  logic [31:0] hw_set;
  logic [31:0] w1s_bits;
  logic [31:0] next_new_event;
  logic [31:0] gated_event;
  logic [31:0] irq_status;
  logic [31:0] irq_mask;
  logic [31:0] rd_value;
  logic [31:0] rdata;

  // Address decode, shared by the address and the data phase.
  function automatic i2c_evt_pkg::reg_sel_t decode(
    input logic [31:0] addr
  );
    i2c_evt_pkg::reg_sel_t sel;
    sel = i2c_evt_pkg::SEL_NONE;
    if (addr == `OFF_EVENT_CLR) begin
      sel = i2c_evt_pkg::SEL_EVENT_CLR;
    end else if (addr == `OFF_IRQ_STATUS) begin
      sel = i2c_evt_pkg::SEL_IRQ_STATUS;
    end else if (addr == `OFF_NEW_EVENT) begin
      sel = i2c_evt_pkg::SEL_NEW_EVENT;
    end else if (addr == `OFF_ENABLE) begin
      sel = i2c_evt_pkg::SEL_ENABLE;
    end else if (addr == `OFF_IRQ_MASK) begin
      sel = i2c_evt_pkg::SEL_IRQ_MASK;
    end else if (addr == `OFF_SOFT_RESET) begin
      sel = i2c_evt_pkg::SEL_SOFT_RESET;
    end
    return sel;
  endfunction : decode

  // The slave never inserts wait states and never signals an error.
  assign bus_rsp.hreadyout = 1'b1;
  assign bus_rsp.hresp = 1'b0;
  assign bus_rsp.hrdata = rdata;

  assign addr_ok = bus_req.hsel && bus_req.hready &&
    bus_req.htrans == `HTRANS_NONSEQ;
  assign addr_rd = addr_ok && !bus_req.hwrite;
  assign addr_sel = decode(bus_req.haddr);

  always_ff @(posedge clock) begin
    if (rst) begin
      data_wr <= 1'b0;
      data_sel <= i2c_evt_pkg::SEL_NONE;
    end else begin
      data_wr <= addr_ok && bus_req.hwrite;
      data_sel <= addr_ok ? addr_sel : i2c_evt_pkg::SEL_NONE;
    end
  end

  assign wr_new = data_wr && data_sel == i2c_evt_pkg::SEL_NEW_EVENT;
  assign wr_enable = data_wr && data_sel == i2c_evt_pkg::SEL_ENABLE;
  assign wr_event_clr = data_wr && data_sel == i2c_evt_pkg::SEL_EVENT_CLR;
  assign wr_status = data_wr && data_sel == i2c_evt_pkg::SEL_IRQ_STATUS;
  assign wr_irq_mask = data_wr && data_sel == i2c_evt_pkg::SEL_IRQ_MASK;
  assign wr_soft_reset = data_wr &&
    data_sel == i2c_evt_pkg::SEL_SOFT_RESET;

  // Reading interrupt status is the snapshot; it is taken in the address
  // phase so the returned word and the clear belong to the same edge.
  assign status_rd = addr_rd && addr_sel == i2c_evt_pkg::SEL_IRQ_STATUS;
  assign clear_new = wr_event_clr || status_rd;

  // Reserved positions are masked off on every path into the registers.
  assign w1s_bits = bus_req.hwdata & `NEW_IMPL;
  assign hw_set = event_in & `NEW_IMPL;

  // Hardware and software sets win over a clear in the same cycle, but the
  // soft reset beats everything so no event leaks out while it is held.
  always_comb begin
    next_new_event = new_event;
    if (clear_new) begin
      next_new_event = `ZERO_WORD;
    end
    next_new_event = next_new_event | hw_set;
    if (wr_new) begin
      next_new_event = next_new_event | w1s_bits;
    end
    if (soft_block_reset) begin
      next_new_event = `ZERO_WORD;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      new_event <= `ZERO_WORD;
    end else begin
      new_event <= next_new_event;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      event_enable <= `ENB_RESET;
    end else if (wr_enable) begin
      event_enable <= bus_req.hwdata & `ENB_IMPL;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_mask <= `IRQ_MASK_RESET;
    end else if (wr_irq_mask) begin
      irq_mask <= bus_req.hwdata & `ENB_IMPL;
    end
  end

  // The soft reset stays set until software writes it back to zero.
  always_ff @(posedge clock) begin
    if (rst) begin
      soft_block_reset <= 1'b0;
    end else if (wr_soft_reset) begin
      soft_block_reset <= bus_req.hwdata[`SRST_BIT];
    end
  end

  // Only enabled events may land in the interrupt status.
  assign gated_event = latched_event & event_enable;

  sticky_w1c #(
    .WIDTH(32)
  ) status_bits (
    .clock(clock),
    .rst(rst),
    .set(gated_event),
    .clear_wr(wr_status),
    .clear_data(bus_req.hwdata),
    .status(irq_status)
  );

  assign irq = |(irq_status & irq_mask);

  always_comb begin
    rd_value = `ZERO_WORD;
    case (addr_sel)
      i2c_evt_pkg::SEL_IRQ_STATUS: begin
        rd_value = irq_status;
      end
      i2c_evt_pkg::SEL_NEW_EVENT: begin
        rd_value = new_event;
      end
      i2c_evt_pkg::SEL_ENABLE: begin
        rd_value = event_enable;
      end
      i2c_evt_pkg::SEL_IRQ_MASK: begin
        rd_value = irq_mask;
      end
      i2c_evt_pkg::SEL_SOFT_RESET: begin
        rd_value = {31'h00000000, soft_block_reset};
      end
      default: begin
        rd_value = `ZERO_WORD;
      end
    endcase
  end

  // Read data is captured at the address phase edge. A read that follows a
  // write with no idle gap would see the value from before that write.
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= `ZERO_WORD;
    end else if (addr_rd) begin
      rdata <= rd_value;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  gate_blocks_a:
  assert property (
    ((irq_status & ~$past(irq_status)) & ~$past(event_enable)) == '0
  ) else $error("status bit rose while its enable was off");

  mask_reset_a:
  assert property ($fell(rst) |-> event_enable == `ENB_RESET)
    else $error("enable mask left reset with a wrong value");

  mask_write_a:
  assert property (
    wr_enable |=> event_enable == ($past(bus_req.hwdata) & `ENB_IMPL)
  ) else $error("enable mask did not take the written word");

  hist_reset_a:
  assert property (
    $fell(rst) |-> !event_enable[`EVB_DIAG_HISTORY_FILLING] ##1
    !event_enable[`EVB_DIAG_HISTORY_FILLING]
  ) else $error("history filling enable not zero after reset");

  cmd_done_a:
  assert property (
    $fell(rst) |-> !event_enable[`EVB_DIAG_COMMAND_DONE] && event_enable[`EVB_SD]
  ) else $error("command done or transaction done enable wrong");

  diag_mbox_a:
  assert property (
    wr_new && !soft_block_reset |=>
    (new_event & $past(w1s_bits) & `GRP_DIAG_MBOX) ==
    ($past(w1s_bits) & `GRP_DIAG_MBOX)
  ) else $error("diagnostic or mailbox event not set by a one");

  slave_err_a:
  assert property (
    wr_new && !soft_block_reset |=>
    (new_event & $past(w1s_bits) & `GRP_SLAVE_ERR) ==
    ($past(w1s_bits) & `GRP_SLAVE_ERR)
  ) else $error("slave error event not set by a one");

  boot_load_a:
  assert property (
    wr_new && !soft_block_reset |=>
    (new_event & $past(w1s_bits) & `GRP_MASTER_BOOT) ==
    ($past(w1s_bits) & `GRP_MASTER_BOOT)
  ) else $error("master done or boot load event not set by a one");

  master_err_a:
  assert property (
    wr_new && !soft_block_reset |=>
    (new_event & $past(w1s_bits) & `GRP_MASTER_ERR) ==
    ($past(w1s_bits) & `GRP_MASTER_ERR)
  ) else $error("master error event not set by a one");

  done_boot_a:
  assert property (
    $fell(rst) |-> event_enable[`EVB_MTD] && event_enable[`EVB_BOOT_LOAD_ERROR]
  ) else $error("master done or boot error enable not one");

  mailbox_enb_a:
  assert property (
    $fell(rst) |-> event_enable[`EVB_INBOX_WRITE] && event_enable[`EVB_OUTBOX_READ]
  ) else $error("mailbox enables not one after reset");

  snapshot_clear_a:
  assert property (
    clear_new && !wr_new && !soft_block_reset |=>
    new_event == $past(hw_set)
  ) else $error("new events survived a clear");

  soft_hold_a:
  assert property (soft_block_reset |=> new_event == `ZERO_WORD)
    else $error("new event asserted under soft reset");

  reserved_zero_a:
  assert property (
    (new_event & ~`NEW_IMPL) == '0 && (event_enable & ~`ENB_IMPL) == '0
  ) else $error("reserved bit set");

  // Interrupt status keeps its bits until software writes ones to them.
  status_keep_a:
  assert property (
    !wr_status |=> (irq_status & $past(irq_status)) == $past(irq_status)
  ) else $error("status bit dropped without a clear");

  status_set_a:
  assert property (
    gated_event != '0 |=>
    (irq_status & $past(gated_event)) == $past(gated_event)
  ) else $error("enabled event missing from status");

  // A clear that meets a new event in the same cycle must lose to it.
  status_clear_a:
  assert property (
    wr_status |=>
    (irq_status & $past(bus_req.hwdata) & ~$past(gated_event)) == '0
  ) else $error("status bit survived its clear");

  enable_hold_a:
  assert property (!wr_enable |=> $stable(event_enable))
    else $error("enable mask changed without a write");

  enable_read_a:
  assert property (
    addr_rd && addr_sel == i2c_evt_pkg::SEL_ENABLE |=>
    bus_rsp.hrdata == $past(event_enable)
  ) else $error("enable mask read returned a wrong word");

  new_keep_a:
  assert property (
    !clear_new && !soft_block_reset |=>
    (new_event & $past(new_event)) == $past(new_event)
  ) else $error("new event bit dropped without a clear");

  hw_beats_clear_a:
  assert property (
    !soft_block_reset |=>
    (new_event & $past(hw_set)) == $past(hw_set)
  ) else $error("hardware event lost");

  soft_keep_a:
  assert property (!wr_soft_reset |=> $stable(soft_block_reset))
    else $error("soft reset changed without a write");

  reserved_more_a:
  assert property (
    (irq_status & ~`ENB_IMPL) == '0 && (irq_mask & ~`ENB_IMPL) == '0
  ) else $error("reserved status or mask bit set");

endmodule : i2c_event_enable_gating

// *** test/i2c_event_enable_gating_bench.sv ***
// Self-checking bench for the event enable and new-event registers.
`timescale 1ns/1ps
`include "i2c_evt_regs.svh"

module i2c_event_enable_gating_bench;
  logic clock, rst, hsel, hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, event_in, latched_event, rd, e, l, w, acc;
  logic [31:0] new_event, event_enable;
  logic soft_block_reset, irq;
  i2c_evt_pkg::ahb_req_t bus_req;
  i2c_evt_pkg::ahb_rsp_t bus_rsp;
  int n_fail, comparisons, seed, i;

  // The single slave's ready is fed back as the bus ready.
  assign bus_req = {hsel, haddr, htrans, hwrite, hsize, hwdata,
                    bus_rsp.hreadyout};

  i2c_event_enable_gating i2c_event_enable_gating_inst (
    .clock(clock),
    .rst(rst),
    .bus_req(bus_req),
    .bus_rsp(bus_rsp),
    .event_in(event_in),
    .latched_event(latched_event),
    .new_event(new_event),
    .event_enable(event_enable),
    .soft_block_reset(soft_block_reset),
    .irq(irq)
  );

  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask : check

  // Bounded wait for ready sampled high at a rising edge.
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (bus_rsp.hreadyout !== 1'h1 && k < 50);
    if (bus_rsp.hreadyout !== 1'h1) begin
      n_fail++;
      $display("BAD %0t bus wait ran out", $time);
      stop_test();
    end
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= `HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = bus_rsp.hrdata;
    check({31'h0, bus_rsp.hresp}, 32'h0, "okay response");
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask : wr

  task automatic rdx(input logic [31:0] a);
    bus(1'h0, a, `ZERO_WORD, rd);
  endtask : rdx

  // Registers update at the ending edge; look once they have settled.
  task automatic settle();
    @(negedge clock);
  endtask : settle

  initial begin
    seed = 89307;
    n_fail = 0;
    comparisons = 0;
    rst = 1'h1;
    hsel = 1'h0;
    hwrite = 1'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    event_in = 32'h0;
    latched_event = 32'h0;
    repeat (10) @(posedge clock);
    rst <= 1'h0;

    rdx(`OFF_ENABLE);
    check(rd, 32'h74DE5F3F, "enable reset");
    check({31'h0, rd[31-6]}, 32'h0, "history enable");
    check({30'h0, rd[31-7], rd[31-3]}, 32'h1, "cmd and xact enable");
    check({30'h0, rd[31-17], rd[31-20]}, 32'h3, "master enables");
    check({30'h0, rd[31-8], rd[31-9]}, 32'h3, "mailbox enables");
    check(event_enable, 32'h74DE5F3F, "enable port");
    rdx(`OFF_NEW_EVENT);
    check(rd, 32'h0, "new event reset");
    rdx(32'h0001D3FC);
    check(rd, 32'h0, "unmapped read");
    $display("test reset values done");

    for (i = 0; i < 8; i++) begin
      e = (i == 0) ? `ENB_RESET : $random(seed);
      l = (i == 0) ? 32'hFFFFFFFF : $random(seed);
      wr(`OFF_ENABLE, e);
      rdx(`OFF_ENABLE);
      check(rd, e & `ENB_IMPL, "enable readback");
      wr(`OFF_IRQ_STATUS, 32'hFFFFFFFF);
      @(posedge clock);
      latched_event <= l;
      @(posedge clock);
      latched_event <= 32'h0;
      rdx(`OFF_IRQ_STATUS);
      check(rd, l & e & `ENB_IMPL, "gated status");
      wr(`OFF_IRQ_MASK, 32'hFFFFFFFF);
      settle();
      check({31'h0, irq}, {31'h0, (l & e & `ENB_IMPL) != 0}, "irq on");
      rdx(`OFF_IRQ_MASK);
      check(rd, `ENB_IMPL, "mask readback");
      wr(`OFF_IRQ_MASK, 32'h0);
      settle();
      check({31'h0, irq}, 32'h0, "irq masked");
    end
    wr(32'h0001D3FC, 32'h0);
    rdx(`OFF_ENABLE);
    check(rd, e & `ENB_IMPL, "unmapped write ignored");
    $display("test enable gating done");

    for (i = 0; i < 8; i++) begin
      w = (i == 0) ? 32'hFFFFFFFF : $random(seed);
      wr(`OFF_EVENT_CLR, 32'h0);
      wr(`OFF_NEW_EVENT, w);
      acc = w & `NEW_IMPL;
      rdx(`OFF_NEW_EVENT);
      check(rd, acc, "w1s set");
      check(rd & `GRP_SLAVE_ERR, w & `GRP_SLAVE_ERR, "slave group");
      check(rd & `GRP_MASTER_BOOT, w & `GRP_MASTER_BOOT, "boot");
      check(rd & `GRP_MASTER_ERR, w & `GRP_MASTER_ERR, "master");
      w = $random(seed);
      wr(`OFF_NEW_EVENT, w);
      settle();
      check(new_event, acc | (w & `NEW_IMPL), "w1s keeps ones");
      if (i[0]) begin
        wr(`OFF_EVENT_CLR, 32'h0);
      end else begin
        rdx(`OFF_IRQ_STATUS);
      end
      settle();
      check(new_event, 32'h0, "clear on event or snapshot");
      w = $random(seed);
      @(posedge clock);
      event_in <= w;
      @(posedge clock);
      event_in <= 32'h0;
      rdx(`OFF_NEW_EVENT);
      check(rd, w & `NEW_IMPL, "hardware event");
    end
    $display("test new events done");

    wr(`OFF_SOFT_RESET, 32'h1);
    settle();
    check({31'h0, soft_block_reset}, 32'h1, "soft reset on");
    rdx(`OFF_SOFT_RESET);
    check(rd, 32'h1, "soft reset readback");
    wr(`OFF_NEW_EVENT, 32'hFFFFFFFF);
    @(posedge clock);
    event_in <= 32'hFFFFFFFF;
    @(posedge clock);
    event_in <= 32'h0;
    rdx(`OFF_NEW_EVENT);
    check(rd, 32'h0, "held clear in soft reset");
    wr(`OFF_SOFT_RESET, 32'h0);
    wr(`OFF_NEW_EVENT, 32'hFFFFFFFF);
    rdx(`OFF_NEW_EVENT);
    check(rd, `NEW_IMPL, "set after soft reset");
    $display("test soft reset done");
    stop_test();
  end

  initial begin
    repeat (60000) @(posedge clock);
    n_fail++;
    $display("BAD %0t run limit reached", $time);
    stop_test();
  end
endmodule : i2c_event_enable_gating_bench
